// File: ahm_pkg.sv
// Package of register offsets, codes and field positions for the host mailbox port.
package ahm_pkg;
  localparam logic [7:0] ADDR_INBOUND_DATA   = 8'h54;
  localparam logic [7:0] ADDR_DIAG_SENSE     = 8'h55;
  localparam logic [7:0] ADDR_HANDSHAKE      = 8'h56;
  localparam logic [7:0] ADDR_IFACE_CONTROL  = 8'h57;
  localparam logic [7:0] ADDR_ATTENTION      = 8'h58;
  localparam logic [7:0] ADDR_CMD_READBACK   = 8'h59;
  localparam logic [7:0] ADDR_OUTBOUND       = 8'h50;
  localparam logic [7:0] CTRL_CONFIGURE      = 8'hc3;
  localparam logic [7:0] CTRL_IRQ_ENABLE     = 8'h09;
  localparam logic [7:0] CTRL_IRQ_DISABLE    = 8'h08;
  localparam int         HS_OUT_EMPTY_BIT    = 7;
  localparam int         HS_IN_FULL_BIT      = 5;
  localparam int         HS_IRQ_BIT          = 3;
  localparam logic [2:0] ID_INFO             = 3'h0;
  localparam logic [2:0] ID_BLOCK_DATA_A     = 3'h2;
  localparam logic [2:0] ID_BLOCK_DATA_B     = 3'h3;
  localparam logic [2:0] ID_BLOCK_START      = 3'h4;
  localparam logic [5:0] CMD_RESET           = 6'h00;
  localparam logic [7:0] DATA_RESET          = 8'h00;
  localparam int         FIFO_WIDTH          = 11;
  localparam int         FIFO_DEPTH          = 32;
  typedef enum logic [1:0] {ST_IDLE, ST_SINGLE, ST_COUNT, ST_BLOCK} ahm_post_t;
endpackage

// File: ahm_stream_if.sv
// Interface carrying tagged inbound bytes between the FIFO and the mailbox core.
`timescale 1ns/1ps
`default_nettype none
interface ahm_stream_if;
  logic       valid;
  logic       ready;
  logic [2:0] id;
  logic [7:0] data;
  modport src (output valid, output id, output data, input ready);
  modport dst (input valid, input id, input data, output ready);
endinterface
`default_nettype wire

// File: ahm_fifo.sv
// Parameterised valid/ready FIFO holding tagged bytes bound for the host.
`timescale 1ns/1ps
`default_nettype none
module ahm_fifo #(
  parameter int WIDTH = 11,
  parameter int DEPTH = 32
) (
  // Clock and reset
  input  wire logic             clk,
  input  wire logic             nrst,
  // Fill side
  input  wire logic             in_valid,
  output logic                  in_ready,
  input  wire logic [WIDTH-1:0] in_data,
  // Drain side
  ahm_stream_if.src             out
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0]    wr_ptr_reg;
  logic [AW-1:0]    rd_ptr_reg;
  logic [AW:0]      count_reg;
  logic             push;
  logic             pop;

  assign in_ready  = (count_reg != (AW+1)'(DEPTH));
  assign out.valid = (count_reg != '0);
  assign {out.id, out.data} = mem[rd_ptr_reg];
  assign push = in_valid && in_ready;
  assign pop  = out.valid && out.ready;

  always_ff @(posedge clk) begin
    if (push) begin
      mem[wr_ptr_reg] <= in_data;
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      count_reg  <= '0;
    end else begin
      if (push) begin
        wr_ptr_reg <= wr_ptr_reg + 1'b1;
      end
      if (pop) begin
        rd_ptr_reg <= rd_ptr_reg + 1'b1;
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
    end
  end
endmodule
`default_nettype wire

// File: ahm_mailbox.sv
// Host mailbox port: outbound command latch, inbound buffer and handshake status.
`timescale 1ns/1ps
`default_nettype none
// How it works
// - Host write latches command and data together
// - Host write clears outbound-empty bit, interrupts controller
// - Controller fetches command before data
// - Controller data read sets outbound-empty again
// - Status posted with identifiers zero, three, four
// - Post only when inbound buffer empty
// - Identifier written before its data byte
// - Loading inbound buffer sets full, raises request
// - Host data read clears request, frees buffer
// - Block starts with identifier four and count
// - Block bytes carry identifier two or three
// - Exactly count bytes follow the block start
// - Block procedure for tablet and dumps
// - Control 09 enables, 08 disables request
// - Attention bit 0 readable, any write clears
// - Option-select write triggers hardware reset
// - Handshake bit 7 outbound, bit 5 inbound
// - Readback returns bits 13-8 of last write
module ahm_mailbox
  import ahm_pkg::*;
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        nrst,
  // Host I/O bus
  input  wire logic [7:0]  io_addr,
  input  wire logic        io_write,
  input  wire logic        io_read,
  input  wire logic [15:0] io_wdata,
  output logic [7:0]       io_rdata,
  output logic             host_irq,
  // Option-select reset, attention event and diagnostic sense pins
  input  wire logic        option_select_write,
  input  wire logic        attention_event,
  input  wire logic [7:0]  diagnostic_sense_port,
  // Controller side: outbound mailbox
  output logic             ctl_outbound_irq,
  output logic [5:0]       ctl_command,
  output logic [7:0]       ctl_data,
  input  wire logic        ctl_command_read,
  input  wire logic        ctl_data_read,
  // Controller side: inbound posts, block status and adapter reset
  input  wire logic        ctl_post_valid,
  output logic             ctl_post_ready,
  input  wire logic [2:0]  ctl_post_id,
  input  wire logic [7:0]  ctl_post_data,
  output logic             ctl_block_busy,
  output logic             adapter_reset
);
  ahm_stream_if      stream ();
  logic [1:0]        sense_sync_reg [8];
  logic [7:0]        sense_reg;
  logic [1:0]        attn_sync_reg;
  logic              attn_prev_reg;
  logic [1:0]        opt_sync_reg;
  logic              opt_prev_reg;
  logic              out_empty_reg;
  logic              cmd_fetched_reg;
  logic [5:0]        cmd_latch_reg;
  logic [7:0]        data_latch_reg;
  logic [5:0]        readback_reg;
  logic              in_full_reg;
  logic [2:0]        in_id_reg;
  logic [7:0]        in_data_reg;
  logic              irq_en_reg;
  logic              attention_reg;
  ahm_post_t         post_state_reg;
  logic [7:0]        block_left_reg;
  logic              wr_strobe;
  logic              rd_strobe;
  logic              load;
  logic              host_data_read;
  logic              attn_rise;
  logic              in_ready_unused;

  assign wr_strobe      = io_write && nrst;
  assign rd_strobe      = io_read && nrst;
  assign host_data_read = rd_strobe && (io_addr == ADDR_INBOUND_DATA);
  assign attn_rise      = attn_sync_reg[1] && !attn_prev_reg;

  // Posts are queued so the controller is held for host latency only once all 32 FIFO entries are full.
  ahm_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk      (clk),
    .nrst     (nrst),
    .in_valid (ctl_post_valid),
    .in_ready (in_ready_unused),
    .in_data  ({ctl_post_id, ctl_post_data}),
    .out      (stream)
  );

  // The buffer only loads when empty, so a post never overwrites an unread byte.
  assign load         = stream.valid && !in_full_reg;
  assign stream.ready = load;

  always_ff @(posedge clk) begin
    ctl_post_ready <= nrst ? in_ready_unused : 1'b0;
  end

  // Inputs from pins pass two flip-flops; the sense port passes a third.
  always_ff @(posedge clk) begin
    for (int i = 0; i < 8; i++) begin
      sense_sync_reg[i] <= {sense_sync_reg[i][0], diagnostic_sense_port[i]};
      sense_reg[i]      <= sense_sync_reg[i][1];
    end
    attn_sync_reg <= {attn_sync_reg[0], attention_event};
    opt_sync_reg  <= {opt_sync_reg[0], option_select_write};
    // Edge history is not reset, so a pin held high across reset gives no false edge.
    attn_prev_reg <= attn_sync_reg[1];
    opt_prev_reg  <= opt_sync_reg[1];
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      adapter_reset <= 1'b0;
    end else begin
      adapter_reset <= opt_sync_reg[1] && !opt_prev_reg;
    end
  end

  // Outbound mailbox.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      out_empty_reg   <= 1'b1;
      cmd_fetched_reg <= 1'b0;
      cmd_latch_reg   <= CMD_RESET;
      data_latch_reg  <= DATA_RESET;
      readback_reg    <= CMD_RESET;
    end else begin
      if (wr_strobe && (io_addr == ADDR_OUTBOUND)) begin
        readback_reg <= io_wdata[13:8];
      end
      // A write while still full is dropped to protect the pending pair, but a controller
      // read in that same cycle must still count, or the latch would never free.
      if (wr_strobe && (io_addr == ADDR_OUTBOUND) && out_empty_reg) begin
        cmd_latch_reg   <= io_wdata[13:8];
        data_latch_reg  <= io_wdata[7:0];
        out_empty_reg   <= 1'b0;
        cmd_fetched_reg <= 1'b0;
      end else if (!out_empty_reg) begin
        if (ctl_command_read) begin
          cmd_fetched_reg <= 1'b1;
        end
        // A data read before the command fetch does not free the latch.
        if (ctl_data_read && (cmd_fetched_reg || ctl_command_read)) begin
          out_empty_reg <= 1'b1;
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (!nrst) begin
      ctl_outbound_irq <= 1'b0;
      ctl_command      <= CMD_RESET;
      ctl_data         <= DATA_RESET;
    end else begin
      ctl_outbound_irq <= !out_empty_reg;
      ctl_command      <= cmd_latch_reg;
      ctl_data         <= data_latch_reg;
    end
  end

  // Interface control.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      irq_en_reg <= 1'b0;
    end else if (wr_strobe && (io_addr == ADDR_IFACE_CONTROL)) begin
      if (io_wdata[7:0] == CTRL_IRQ_ENABLE) begin
        irq_en_reg <= 1'b1;
      end else if (io_wdata[7:0] == CTRL_IRQ_DISABLE || io_wdata[7:0] == CTRL_CONFIGURE) begin
        irq_en_reg <= 1'b0;
      end
    end
  end

  // Inbound buffer; load needs empty, so a host read in the same cycle frees nothing and the load wins.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      in_full_reg <= 1'b0;
      in_id_reg   <= ID_INFO;
      in_data_reg <= DATA_RESET;
    end else if (load) begin
      in_id_reg   <= stream.id;
      in_data_reg <= stream.data;
      in_full_reg <= 1'b1;
    end else if (host_data_read) begin
      in_full_reg <= 1'b0;
    end
  end

  always_ff @(posedge clk) begin
    host_irq <= nrst && in_full_reg && irq_en_reg;
  end

  // Block tracking: counts bytes after an identifier-four count byte.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      post_state_reg <= ST_IDLE;
      block_left_reg <= DATA_RESET;
    end else if (load) begin
      case (post_state_reg)
        ST_BLOCK: begin
          if (block_left_reg == 8'h01) begin
            post_state_reg <= ST_IDLE;
          end
          block_left_reg <= block_left_reg - 8'h01;
        end
        default: begin
          if (stream.id == ID_BLOCK_START && stream.data != DATA_RESET) begin
            post_state_reg <= ST_BLOCK;
            block_left_reg <= stream.data;
          end else begin
            post_state_reg <= ST_SINGLE;
          end
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    ctl_block_busy <= nrst && (post_state_reg == ST_BLOCK);
  end

  // Attention flag: a new event beats a clearing write.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      attention_reg <= 1'b0;
    end else if (attn_rise) begin
      attention_reg <= 1'b1;
    end else if (wr_strobe && (io_addr == ADDR_ATTENTION)) begin
      attention_reg <= 1'b0;
    end
  end

  // Read data is registered, valid the cycle after io_read.
  always_ff @(posedge clk) begin
    if (!nrst) begin
      io_rdata <= DATA_RESET;
    end else if (rd_strobe) begin
      case (io_addr)
        ADDR_INBOUND_DATA:  io_rdata <= in_data_reg;
        ADDR_DIAG_SENSE:    io_rdata <= sense_reg;
        ADDR_HANDSHAKE:     io_rdata <= {out_empty_reg, 1'b0, in_full_reg, 1'b0,
                                         in_full_reg && irq_en_reg, in_id_reg};
        ADDR_ATTENTION:     io_rdata <= {7'h00, attention_reg};
        ADDR_CMD_READBACK:  io_rdata <= {2'h0, readback_reg};
        default:            io_rdata <= DATA_RESET;
      endcase
    end
  end
endmodule
`default_nettype wire

// File: ahm_mailbox_monitor.sv
// Checker for the mailbox port's host and controller pins.
`timescale 1ns/1ps
`default_nettype none
module ahm_mailbox_monitor
  import ahm_pkg::*;
(
  // Watched ports
  input wire logic        clk,
  input wire logic        nrst,
  input wire logic [7:0]  io_addr,
  input wire logic        io_write,
  input wire logic        io_read,
  input wire logic [15:0] io_wdata,
  input wire logic [7:0]  io_rdata,
  input wire logic        host_irq,
  input wire logic        option_select_write,
  input wire logic        attention_event,
  input wire logic        ctl_outbound_irq,
  input wire logic [5:0]  ctl_command,
  input wire logic [7:0]  ctl_data,
  input wire logic        ctl_command_read,
  input wire logic        ctl_data_read,
  input wire logic        ctl_block_busy,
  input wire logic        adapter_reset
);
  default clocking @(posedge clk); endclocking
  default disable iff (!nrst);
  // A write on a free latch; a write landing while full is dropped, so it is excluded.
  wire out_new = io_write && io_addr == ADDR_OUTBOUND && !ctl_outbound_irq && !ctl_data_read;
  property p_out_full;
    out_new |-> ##2 ctl_outbound_irq;
  endproperty
  a_out_full: assert property (p_out_full) else $error("outbound flag late");
  property p_out_latch;
    out_new && !$past(io_write) |-> ##2 ctl_data == $past(io_wdata[7:0], 2)
      && ctl_command == $past(io_wdata[13:8], 2);
  endproperty
  a_out_latch: assert property (p_out_latch) else $error("latched pair wrong");
  property p_out_free;
    ctl_command_read && ctl_data_read && ctl_outbound_irq && !io_write |-> ##2 !ctl_outbound_irq;
  endproperty
  a_out_free: assert property (p_out_free) else $error("outbound flag stuck");
  property p_hold;
    ctl_outbound_irq && $past(ctl_outbound_irq) |-> $stable(ctl_data) && $stable(ctl_command);
  endproperty
  a_hold: assert property (p_hold) else $error("latch changed while full");
  property p_readback;
    io_write && io_addr == ADDR_OUTBOUND ##1 !io_write
      ##1 io_read && io_addr == ADDR_CMD_READBACK
      |=> io_rdata[5:0] == $past(io_wdata[13:8], 3);
  endproperty
  a_readback: assert property (p_readback) else $error("readback wrong");
  property p_in_free;
    io_read && io_addr == ADDR_INBOUND_DATA && host_irq |-> ##[1:3] !host_irq;
  endproperty
  a_in_free: assert property (p_in_free) else $error("request not dropped");
  property p_irq_off;
    io_write && io_addr == ADDR_IFACE_CONTROL && io_wdata[7:0] == CTRL_IRQ_DISABLE
      ##1 (!io_write) [*2] |-> (!host_irq) [*3];
  endproperty
  a_irq_off: assert property (p_irq_off) else $error("request while disabled");
  property p_reset;
    $rose(option_select_write) |-> ##[1:6] adapter_reset ##1 !adapter_reset;
  endproperty
  a_reset: assert property (p_reset) else $error("adapter reset pulse wrong");
  property p_attn;
    (!attention_event) [*3] ##0 (io_write && io_addr == ADDR_ATTENTION)
      ##2 io_read && io_addr == ADDR_ATTENTION |=> !io_rdata[0];
  endproperty
  a_attn: assert property (p_attn) else $error("attention not cleared");
  c_block: cover property (ctl_block_busy);
  c_irq: cover property (host_irq ##1 !host_irq);
  c_reset: cover property (adapter_reset);
endmodule
bind ahm_mailbox ahm_mailbox_monitor u_mon (.*);
`default_nettype wire

// File: ahm_host_model.sv
// Host bus model issuing single-cycle I/O reads and writes.
`timescale 1ns/1ps
`default_nettype none
module ahm_host_model (
  // Clock and answer
  input  wire logic        clk,
  input  wire logic [7:0]  io_rdata,
  // Host bus
  output logic [7:0]       io_addr,
  output logic             io_write,
  output logic             io_read,
  output logic [15:0]      io_wdata
);
  initial begin
    io_addr = 8'h00;
    io_write = 1'b0;
    io_read = 1'b0;
    io_wdata = 16'h0000;
  end
  // Strobes last one whole cycle, so each access is taken exactly once.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge clk);
    io_addr = a;
    io_wdata = d;
    io_write = 1'b1;
    @(negedge clk);
    io_write = 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(negedge clk);
    io_addr = a;
    io_read = 1'b1;
    @(negedge clk);
    io_read = 1'b0;
    d = io_rdata;
  endtask
endmodule
`default_nettype wire

// File: test_adapter_host_mailbox_port.sv
// Self-checking bench for the host mailbox port.
`timescale 1ns/1ps
`default_nettype none
module test_adapter_host_mailbox_port
  import ahm_pkg::*;
();
  logic        clk;
  logic        nrst;
  logic [7:0]  io_addr;
  logic        io_write;
  logic        io_read;
  logic [15:0] io_wdata;
  logic [7:0]  io_rdata;
  logic        host_irq;
  logic        option_select_write;
  logic        attention_event;
  logic [7:0]  diagnostic_sense_port;
  logic        ctl_outbound_irq;
  logic [5:0]  ctl_command;
  logic [7:0]  ctl_data;
  logic        ctl_command_read;
  logic        ctl_data_read;
  logic        ctl_post_valid;
  logic        ctl_post_ready;
  logic [2:0]  ctl_post_id;
  logic [7:0]  ctl_post_data;
  logic        ctl_block_busy;
  logic        adapter_reset;
  int          failures;
  int          compares;
  int          n;
  logic [7:0]  r;
  ahm_mailbox DUT (.*);
  ahm_host_model host (.*);
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic conclude;
    if (failures == 0 && compares > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      failures++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic post(input logic [2:0] id, input logic [7:0] d);
    ctl_post_valid = 1'b1;
    ctl_post_id = id;
    ctl_post_data = d;
    @(negedge clk);
    ctl_post_valid = 1'b0;
  endtask
  task automatic pulse_ctl(input logic cmd);
    @(negedge clk);
    ctl_command_read = cmd;
    ctl_data_read = 1'b1;
    @(negedge clk);
    ctl_command_read = 1'b0;
    ctl_data_read = 1'b0;
    repeat (3) @(negedge clk);
  endtask
  // The identifier is only trusted once the full bit is seen, then the data is read.
  task automatic get(input logic [2:0] id, input logic [7:0] d, input logic en);
    logic [7:0] s;
    s = 8'h00;
    for (int k = 0; k < 60 && s[5] !== 1'b1; k++) host.rd(ADDR_HANDSHAKE, s);
    chk(s, {4'ha, en, id});
    @(negedge clk);
    chk(host_irq, en);
    host.rd(ADDR_INBOUND_DATA, s);
    chk(s, d);
  endtask
  initial begin
    #400000;
    failures++;
    conclude();
  end
  initial begin
    failures = 0;
    compares = 0;
    nrst = 1'b0;
    option_select_write = 1'b0;
    attention_event = 1'b0;
    diagnostic_sense_port = 8'h96;
    ctl_command_read = 1'b0;
    ctl_data_read = 1'b0;
    ctl_post_valid = 1'b0;
    ctl_post_id = 3'h0;
    ctl_post_data = 8'h00;
    repeat (20) @(negedge clk);
    nrst = 1'b1;
    repeat (2) @(negedge clk);
    host.wr(ADDR_IFACE_CONTROL, 16'h00c3);
    host.wr(ADDR_IFACE_CONTROL, 16'h0009);
    host.rd(ADDR_HANDSHAKE, r);
    chk(r[7], 1'b1);
    host.wr(ADDR_OUTBOUND, 16'hea5c);
    host.rd(ADDR_CMD_READBACK, r);
    chk(r[5:0], 6'h2a);
    host.rd(ADDR_HANDSHAKE, r);
    chk({r[7], ctl_outbound_irq}, 2'h1);
    host.wr(ADDR_OUTBOUND, 16'h0133);
    host.rd(ADDR_CMD_READBACK, r);
    chk(r[5:0], 6'h01);
    chk({ctl_command, ctl_data}, 14'h2a5c);
    pulse_ctl(1'b0);
    chk(ctl_outbound_irq, 1'b1);
    pulse_ctl(1'b1);
    chk(ctl_outbound_irq, 1'b0);
    n = 0;
    repeat (40) begin
      @(negedge clk);
      if (ctl_post_ready === 1'b1) begin
        post(n[0] ? ID_BLOCK_DATA_B : ID_INFO, n[7:0]);
        n++;
      end
    end
    chk(n[15:0], 16'(FIFO_DEPTH + 1));
    chk(ctl_post_ready, 1'b0);
    for (int i = 0; i < n; i++) get(i[0] ? ID_BLOCK_DATA_B : ID_INFO, i[7:0], 1'b1);
    post(ID_BLOCK_START, 8'h02);
    get(ID_BLOCK_START, 8'h02, 1'b1);
    @(negedge clk);
    chk(ctl_block_busy, 1'b1);
    post(ID_BLOCK_DATA_A, 8'ha5);
    get(ID_BLOCK_DATA_A, 8'ha5, 1'b1);
    post(ID_BLOCK_DATA_B, 8'h5a);
    get(ID_BLOCK_DATA_B, 8'h5a, 1'b1);
    repeat (2) @(negedge clk);
    chk(ctl_block_busy, 1'b0);
    post(ID_BLOCK_DATA_B, 8'h3c);
    repeat (6) @(negedge clk);
    host.wr(ADDR_IFACE_CONTROL, 16'h0008);
    get(ID_BLOCK_DATA_B, 8'h3c, 1'b0);
    host.rd(ADDR_DIAG_SENSE, r);
    chk(r, 8'h96);
    host.rd(8'h5a, r);
    chk(r, 8'h00);
    attention_event = 1'b1;
    repeat (8) @(negedge clk);
    attention_event = 1'b0;
    host.rd(ADDR_ATTENTION, r);
    chk(r[0], 1'b1);
    host.wr(ADDR_ATTENTION, 16'h00ff);
    host.rd(ADDR_ATTENTION, r);
    chk(r[0], 1'b0);
    option_select_write = 1'b1;
    n = 0;
    repeat (10) begin
      @(negedge clk);
      if (adapter_reset === 1'b1) n++;
    end
    chk(n[15:0], 16'h0001);
    host.wr(ADDR_OUTBOUND, 16'h0111);
    repeat (3) @(negedge clk);
    nrst = 1'b0;
    repeat (2) @(negedge clk);
    nrst = 1'b1;
    n = 0;
    repeat (4) begin
      @(negedge clk);
      if (adapter_reset === 1'b1) n++;
    end
    chk(n[15:0], 16'h0000);
    chk({ctl_outbound_irq, host_irq, ctl_block_busy}, 3'h0);
    host.rd(ADDR_HANDSHAKE, r);
    chk(r, 8'h80);
    conclude();
  end
endmodule
`default_nettype wire
